// file: rtl/isp_ctrl.sv
// Status readback, poll command and cascade logic of the interrupt controller.
`timescale 1ns/10ps
//
// Summary of operation
// - Pending, in-service and mask registers readable, eight bits.
// - Read-select command then address-low read returns it.
// - Read selection is remembered across reads.
// - Initialization selects pending register for reads.
// - Address-high reads, and address-high writes outside initialization, reach mask directly.
// - Read after poll acts as acknowledge, sets in-service.
// - Poll word: flag plus level; empty gives flag 0, ones.
// - Cascading reaches up to 64 levels.
// - Master-select pin high means master, low slave.
// - Master drives cascade lines; slaves sample them.
// - Master learns slave inputs; slave learns its identifier.
// - Request raised only when the top unmasked pending level outranks in-service.
// - First acknowledge puts slave identifier on cascade lines.
// - Acknowledge sets in-service bit on master and slave.
`include "isp_cfg.svh"
module isp_ctrl (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Processor bus.
  input wire isp_pkg::isp_bus_ctl_t bus_ctl,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Requests and acknowledge.
  input wire logic [7:0] request_input,
  input wire logic ack_pulse_n,
  output logic int_req,
  // Cascade.
  input wire logic master_select_pin,
  input wire logic [2:0] cascade_id_lines_in,
  output logic [2:0] cascade_id_lines_out,
  output logic cascade_id_lines_oe_n
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  isp_pkg::isp_bus_ctl_t ctl_s1, ctl_s2, ctl_s3;
  logic [7:0] data_s1, data_s2, req_s1, req_s2;
  logic ack_s1, ack_s2, ack_s3, master_s1, master_s2;
  logic [2:0] cas_s1, cas_s2;
  // Every pin passes two flops; the third stage feeds edge detection and the write address decode.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl_s1 <= 4'hF;
      ctl_s2 <= 4'hF;
      ctl_s3 <= 4'hF;
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      ack_s3 <= 1'b1;
    end else begin
      ctl_s1 <= bus_ctl;
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
      ack_s1 <= ack_pulse_n;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end
  // Data, requests and cascade pins carry no reset.
  always_ff @(posedge clock) begin
    data_s1 <= data_in;
    data_s2 <= data_s1;
    req_s1 <= request_input;
    req_s2 <= req_s1;
    master_s1 <= master_select_pin;
    master_s2 <= master_s1;
    cas_s1 <= cascade_id_lines_in;
    cas_s2 <= cas_s1;
  end
  // Strobe edges: reads act on the falling edge, writes on the rising.
  logic rd_fall, wr_rise, ack_fall, ack_rise, cmd_write, mask_write;
  logic init_start;
  assign rd_fall = !ctl_s2.cs_n && !ctl_s2.rd_n && ctl_s3.rd_n;
  assign wr_rise = !ctl_s3.cs_n && !ctl_s3.wr_n && ctl_s2.wr_n;
  assign ack_fall = !ack_s2 && ack_s3;
  assign ack_rise = ack_s2 && !ack_s3;
  assign cmd_write = wr_rise && (ctl_s3.a0 == `ISP_ADDR_CMD);
  assign init_start = cmd_write && data_s2[`ISP_INIT_BIT];
  // ----------------------------------------------------------------
  // Registers and initialization
  // ----------------------------------------------------------------
  isp_pkg::isp_init_t init_reg;
  isp_pkg::isp_ack_t ack_reg;
  logic [7:0] pending_reg, level_mask_reg, in_service_reg, in_service_next;
  logic [7:0] vector_reg, cascade_cfg_reg, data_out_reg;
  logic [2:0] ack_level_reg, cas_out_reg;
  logic single_reg, read_sel_reg, poll_armed_reg, int_req_reg;
  logic drive_rd_reg, drive_vec_reg, cas_drive_reg;
  logic hit;
  logic [2:0] hit_level;
  assign mask_write = wr_rise && (ctl_s3.a0 == `ISP_ADDR_MASK)
                      && (init_reg == isp_pkg::ISP_RUN);
  // Sequencer: start word, vector word, cascade word unless single.
  always_ff @(posedge clock) begin
    if (rst) begin
      init_reg <= isp_pkg::ISP_RUN;
      single_reg <= 1'b1;
      vector_reg <= `ISP_VECTOR_RST;
      cascade_cfg_reg <= `ISP_CASCADE_RST;
    end else if (init_start) begin
      init_reg <= isp_pkg::ISP_WAIT_VEC;
      single_reg <= data_s2[`ISP_SNGL_BIT];
    end else if (wr_rise && ctl_s3.a0 == `ISP_ADDR_MASK) begin
      case (init_reg)
        isp_pkg::ISP_WAIT_VEC: begin
          vector_reg <= data_s2;
          init_reg <= single_reg ? isp_pkg::ISP_RUN : isp_pkg::ISP_WAIT_CAS;
        end
        isp_pkg::ISP_WAIT_CAS: begin
          cascade_cfg_reg <= data_s2;
          init_reg <= isp_pkg::ISP_RUN;
        end
        default: init_reg <= isp_pkg::ISP_RUN;
      endcase
    end
  end
  // Mask register, cleared by the start word, written at address high.
  always_ff @(posedge clock) begin
    if (rst || init_start) begin
      level_mask_reg <= `ISP_MASK_RST;
    end else if (mask_write) begin
      level_mask_reg <= data_s2;
    end
  end
  // Read selection and poll arming from the command word.
  always_ff @(posedge clock) begin
    if (rst || init_start) begin
      read_sel_reg <= `ISP_SEL_PENDING;
      poll_armed_reg <= 1'b0;
    end else if (cmd_write && data_s2[`ISP_CMD_BIT]) begin
      if (data_s2[`ISP_RR_BIT]) begin
        read_sel_reg <= data_s2[`ISP_RIS_BIT];
      end
      poll_armed_reg <= data_s2[`ISP_POLL_BIT];
    end else if (rd_fall) begin
      poll_armed_reg <= 1'b0;
    end
  end
  a_select_default: assert property (@(posedge clock) disable iff (rst)
    init_start |=> read_sel_reg == `ISP_SEL_PENDING)
    else $error("selection not reset to pending");
  a_poll_one_shot: assert property (@(posedge clock) disable iff (rst)
    rd_fall && poll_armed_reg && !cmd_write |=> !poll_armed_reg)
    else $error("poll stayed armed after read");
  // Pending levels follow the request pins.
  always_ff @(posedge clock) begin
    pending_reg <= rst ? 8'h00 : req_s2;
  end
  // Priority resolver shared by request output, poll and acknowledge.
  isp_prio prio_u (
    .pending(pending_reg),
    .mask(level_mask_reg),
    .in_service(in_service_reg),
    .hit(hit),
    .level(hit_level)
  );
  // In-service: end-of-service clears the lowest set bit, the highest-priority level; a set wins.
  always_comb begin
    in_service_next = in_service_reg;
    if (cmd_write && !data_s2[`ISP_CMD_BIT] && data_s2[`ISP_EOS_BIT]) begin
      in_service_next = in_service_reg & (in_service_reg - 8'h01);
    end
    if (hit && ((rd_fall && poll_armed_reg) ||
        (ack_fall && ack_reg == isp_pkg::ISP_ACK_IDLE))) begin
      in_service_next[hit_level] = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    in_service_reg <= (rst || init_start) ? `ISP_SERVICE_RST : in_service_next;
  end
  a_poll_sets_svc: assert property (@(posedge clock) disable iff (rst)
    rd_fall && poll_armed_reg && hit && !init_start
    |=> in_service_reg[$past(hit_level)])
    else $error("poll did not set in-service");
  a_poll_empty_keep: assert property (@(posedge clock) disable iff (rst)
    rd_fall && poll_armed_reg && !hit && !cmd_write
    && !(ack_fall && ack_reg == isp_pkg::ISP_ACK_IDLE)
    |=> $stable(in_service_reg))
    else $error("empty poll changed in-service");
  // Request output to the processor or to the master.
  always_ff @(posedge clock) begin
    int_req_reg <= rst ? 1'b0 : hit;
  end
  assign int_req = int_req_reg;
  a_request_rank: assert property (@(posedge clock) disable iff (rst)
    hit ##1 hit |-> int_req)
    else $error("request output not raised");
  // ----------------------------------------------------------------
  // Acknowledge, cascade and read data
  // ----------------------------------------------------------------
  logic is_master, slave_input, responsible;
  assign is_master = master_s2;
  assign slave_input = is_master && !single_reg
                       && cascade_cfg_reg[ack_level_reg];
  // Only the addressed controller places the vector.
  assign responsible = single_reg || (is_master && !slave_input)
                       || (!is_master && cas_s2 == cascade_cfg_reg[2:0]);
  // Two pulse sequence; the first freezes the level.
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg <= isp_pkg::ISP_ACK_IDLE;
      ack_level_reg <= `ISP_NO_LEVEL;
      cas_out_reg <= 3'h0;
      cas_drive_reg <= 1'b0;
    end else begin
      case (ack_reg)
        isp_pkg::ISP_ACK_IDLE: begin
          if (ack_fall) begin
            ack_reg <= isp_pkg::ISP_ACK_FIRST;
            ack_level_reg <= hit_level;
          end
        end
        isp_pkg::ISP_ACK_FIRST: begin
          if (!cas_drive_reg && slave_input) begin
            cas_out_reg <= ack_level_reg;
            cas_drive_reg <= 1'b1;
          end
          if (ack_fall) begin
            ack_reg <= isp_pkg::ISP_ACK_SECOND;
          end
        end
        isp_pkg::ISP_ACK_SECOND: begin
          if (ack_rise) begin
            ack_reg <= isp_pkg::ISP_ACK_IDLE;
            cas_drive_reg <= 1'b0;
          end
        end
        default: ack_reg <= isp_pkg::ISP_ACK_IDLE;
      endcase
    end
  end
  assign cascade_id_lines_out = cas_out_reg;
  assign cascade_id_lines_oe_n = !(cas_drive_reg && is_master);
  a_cascade_drive: assert property (@(posedge clock) disable iff (rst)
    ack_reg == isp_pkg::ISP_ACK_FIRST && slave_input && is_master
    |=> !cascade_id_lines_oe_n && cascade_id_lines_out == $past(ack_level_reg))
    else $error("cascade lines not driven");
  // Poll word: request flag, zero padding, then the level code.
  isp_pkg::isp_poll_word_t poll_word;
  assign poll_word = '{req: hit, zero: 4'h0, level: hit_level};
  // Data word loads on the strobe edge and is driven while it lasts.
  always_ff @(posedge clock) begin
    if (rst) begin
      data_out_reg <= 8'h00;
      drive_rd_reg <= 1'b0;
      drive_vec_reg <= 1'b0;
    end else begin
      if (rd_fall) begin
        drive_rd_reg <= 1'b1;
        if (poll_armed_reg) begin
          data_out_reg <= poll_word;
        end else if (ctl_s2.a0 == `ISP_ADDR_MASK) begin
          data_out_reg <= level_mask_reg;
        end else if (read_sel_reg == `ISP_SEL_SERVICE) begin
          data_out_reg <= in_service_reg;
        end else begin
          data_out_reg <= pending_reg;
        end
      end else if (ctl_s2.rd_n || ctl_s2.cs_n) begin
        drive_rd_reg <= 1'b0;
      end
      if (ack_fall && ack_reg == isp_pkg::ISP_ACK_FIRST && responsible) begin
        drive_vec_reg <= 1'b1;
        data_out_reg <= {vector_reg[7:3], ack_level_reg};
      end else if (ack_s2) begin
        drive_vec_reg <= 1'b0;
      end
    end
  end
  assign data_out = data_out_reg;
  assign data_oe_n = !(drive_rd_reg || drive_vec_reg);
  a_poll_empty_word: assert property (@(posedge clock) disable iff (rst)
    rd_fall && poll_armed_reg && !hit |=> data_out_reg == 8'h07)
    else $error("empty poll word wrong");
  a_poll_hit_word: assert property (@(posedge clock) disable iff (rst)
    rd_fall && poll_armed_reg && hit
    |=> data_out_reg[7] && data_out_reg[2:0] == $past(hit_level))
    else $error("poll word level wrong");
  a_mask_read_back: assert property (@(posedge clock) disable iff (rst)
    rd_fall && !poll_armed_reg && ctl_s2.a0 && !ack_fall
    |=> data_out_reg == $past(level_mask_reg) ##1 !data_oe_n)
    else $error("mask readback wrong");
endmodule : isp_ctrl

// file: include/isp_cfg.svh
// Offsets, field positions, reset values and codes of the status and poll block.
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define ISP_ADDR_CMD 1'b0
`define ISP_ADDR_MASK 1'b1
`define ISP_INIT_BIT 4
`define ISP_SNGL_BIT 1
`define ISP_CMD_BIT 3
`define ISP_EOS_BIT 5
`define ISP_POLL_BIT 2
`define ISP_RR_BIT 1
`define ISP_RIS_BIT 0
`define ISP_SEL_PENDING 1'b0
`define ISP_SEL_SERVICE 1'b1
`define ISP_MASK_RST 8'h00
`define ISP_SERVICE_RST 8'h00
`define ISP_VECTOR_RST 8'h00
`define ISP_CASCADE_RST 8'h00
`define ISP_NO_LEVEL 3'h7
`endif

// file: include/isp_pkg.sv
// Types shared by the status, poll and cascade logic.
package isp_pkg;
  // Processor bus strobes and address line, all active low but a0.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
  } isp_bus_ctl_t;

  // Word returned by a poll read.
  typedef struct packed {
    logic req;
    logic [3:0] zero;
    logic [2:0] level;
  } isp_poll_word_t;

  // Initialization sequencer, Gray coded.
  typedef enum logic [1:0] {
    ISP_RUN = 2'b00,
    ISP_WAIT_VEC = 2'b01,
    ISP_WAIT_CAS = 2'b11
  } isp_init_t;

  // Acknowledge sequence, Gray coded.
  typedef enum logic [1:0] {
    ISP_ACK_IDLE = 2'b00,
    ISP_ACK_FIRST = 2'b01,
    ISP_ACK_SECOND = 2'b11
  } isp_ack_t;
endpackage : isp_pkg

// file: rtl/isp_prio.sv
// Fixed priority resolver: level 0 highest, level 7 lowest.
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_prio (
  // Register contents.
  input wire logic [7:0] pending,
  input wire logic [7:0] mask,
  input wire logic [7:0] in_service,
  // Result.
  output logic hit,
  output logic [2:0] level
);
  // Returns a found flag and the index of the lowest set bit.
  function automatic logic [3:0] first_set(input logic [7:0] v);
    first_set = {1'b0, `ISP_NO_LEVEL};
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 3'(i)};
      end
    end
  endfunction : first_set

  logic [3:0] req;
  logic [3:0] svc;

  // A request wins only if it outranks every level in service.
  always_comb begin
    req = first_set(pending & ~mask);
    svc = first_set(in_service);
    hit = req[3] && (!svc[3] || (req[2:0] < svc[2:0]));
    level = hit ? req[2:0] : `ISP_NO_LEVEL;
  end
endmodule : isp_prio

// file: dv/isp_peer.sv
// Cascade master model that drives the shared identification lines.
`timescale 1ns/10ps
module isp_peer (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Acknowledge seen by every controller.
  input wire logic ack_pulse_n,
  // Identifier to place on the lines.
  input wire logic [2:0] slave_id,
  output logic [2:0] cas
);
  logic prev_reg;
  logic [1:0] phase_reg;

  // Counts acknowledge pulses; lines hold the id from the first pulse on.
  always_ff @(posedge clock) begin
    prev_reg <= ack_pulse_n;
    if (rst) begin
      phase_reg <= 2'h0;
    end else if (prev_reg && !ack_pulse_n) begin
      phase_reg <= phase_reg + 2'h1;
    end else if (!prev_reg && ack_pulse_n && phase_reg == 2'h2) begin
      phase_reg <= 2'h0;
    end
  end

  // Released lines show the inverse of the id, never the last id.
  assign cas = (phase_reg != 2'h0) ? slave_id : ~slave_id;
endmodule : isp_peer

// file: dv/test_irq_status_poll_cascade.sv
// Self-checking bench of the status, poll and cascade block.
`timescale 1ns/10ps
module test_irq_status_poll_cascade;
  logic clock = 1'b0;
  logic rst = 1'b1;
  isp_pkg::isp_bus_ctl_t bus_ctl = 4'hE;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out;
  logic data_oe_n;
  logic [7:0] request_input = 8'h00;
  logic ack_pulse_n = 1'b1;
  logic int_req;
  logic master_select_pin = 1'b1;
  logic [2:0] cas_in, cas_out, peer_cas;
  logic cas_oe_n;
  logic [2:0] slave_id = 3'h5;
  logic [7:0] rd_data;
  logic s_oe, s_cas_oe;
  logic [2:0] s_cas;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  // Clock of 40 ns.
  always #20 clock = ~clock;

  // Shared lines follow the design when it drives, else the peer.
  assign cas_in = cas_oe_n ? peer_cas : cas_out;

  isp_ctrl DUT (.clock(clock), .rst(rst), .bus_ctl(bus_ctl),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .request_input(request_input), .ack_pulse_n(ack_pulse_n),
    .int_req(int_req), .master_select_pin(master_select_pin),
    .cascade_id_lines_in(cas_in), .cascade_id_lines_out(cas_out),
    .cascade_id_lines_oe_n(cas_oe_n));

  isp_peer peer (.clock(clock), .rst(rst), .ack_pulse_n(ack_pulse_n),
    .slave_id(slave_id), .cas(peer_cas));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : chk

  // Write cycle: strobe low five clocks, then released for five clocks.
  task wr(input logic a0, input logic [7:0] d);
    bus_ctl = '{1'b0, 1'b1, 1'b0, a0};
    data_in = d;
    step(5);
    bus_ctl = 4'hE;
    step(5);
  endtask : wr

  // Read cycle: data sampled while the strobe is still low.
  task rd(input logic a0, input logic [7:0] exp, input string name);
    bus_ctl = '{1'b0, 1'b0, 1'b1, a0};
    step(5);
    rd_data = data_out;
    chk("data_oe_n", 8'h00, {7'h00, data_oe_n});
    chk(name, exp, rd_data);
    bus_ctl = 4'hE;
    step(5);
  endtask : rd

  // One acknowledge pulse, outputs sampled near its end.
  task ack;
    ack_pulse_n = 1'b0;
    step(5);
    s_oe = data_oe_n;
    rd_data = data_out;
    s_cas_oe = cas_oe_n;
    s_cas = cas_out;
    ack_pulse_n = 1'b1;
    step(5);
  endtask : ack

  // Start word, vector, and cascade word when not single.
  task init(input logic [7:0] vec, input logic sngl, input logic [7:0] cw);
    wr(1'b0, {6'h04, sngl, 1'b0});
    wr(1'b1, vec);
    if (!sngl) wr(1'b1, cw);
  endtask : init

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_status;
    request_input = 8'h3C;
    init(8'h00, 1'b1, 8'h00);
    rd(1'b1, 8'h00, "mask");
    rd(1'b0, 8'h3C, "pending");
    wr(1'b1, 8'hA5);
    rd(1'b1, 8'hA5, "mask");
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h0B);
    rd(1'b0, 8'h00, "service");
    rd(1'b0, 8'h00, "service");
    wr(1'b0, 8'h0A);
    rd(1'b0, 8'h3C, "pending");
    $display("test status done");
  endtask : t_status

  task t_poll;
    request_input = 8'h28;
    step(4);
    wr(1'b0, 8'h0C);
    rd(1'b0, 8'h83, "poll word");
    rd(1'b0, 8'h28, "pending");
    wr(1'b0, 8'h0B);
    rd(1'b0, 8'h08, "service");
    wr(1'b0, 8'h20);
    request_input = 8'h00;
    step(4);
    wr(1'b0, 8'h0C);
    rd(1'b0, 8'h07, "empty poll");
    rd(1'b0, 8'h00, "service");
    $display("test poll done");
  endtask : t_poll

  task t_req;
    request_input = 8'h04;
    step(6);
    chk("int_req", 8'h01, {7'h00, int_req});
    wr(1'b1, 8'h04);
    step(6);
    chk("int_req", 8'h00, {7'h00, int_req});
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h0C);
    rd(1'b0, 8'h82, "poll word");
    request_input = 8'h10;
    step(6);
    chk("int_req", 8'h00, {7'h00, int_req});
    request_input = 8'h01;
    step(6);
    chk("int_req", 8'h01, {7'h00, int_req});
    wr(1'b0, 8'h20);
    request_input = 8'h00;
    $display("test request done");
  endtask : t_req

  task t_master;
    master_select_pin = 1'b1;
    init(8'h40, 1'b0, 8'h04);
    request_input = 8'h04;
    step(6);
    ack;
    chk("cas oe", 8'h00, {7'h00, s_cas_oe});
    chk("cas id", 8'h02, {5'h00, s_cas});
    ack;
    chk("data oe", 8'h01, {7'h00, s_oe});
    request_input = 8'h00;
    wr(1'b0, 8'h0B);
    rd(1'b0, 8'h04, "service");
    wr(1'b0, 8'h20);
    request_input = 8'h08;
    step(6);
    ack;
    chk("cas oe", 8'h01, {7'h00, s_cas_oe});
    ack;
    chk("data oe", 8'h00, {7'h00, s_oe});
    chk("vector", 8'h43, rd_data);
    request_input = 8'h00;
    $display("test master done");
  endtask : t_master

  task t_slave;
    master_select_pin = 1'b0;
    init(8'h80, 1'b0, 8'h05);
    request_input = 8'h02;
    step(6);
    chk("int_req", 8'h01, {7'h00, int_req});
    slave_id = 3'h5;
    ack;
    chk("cas oe", 8'h01, {7'h00, s_cas_oe});
    ack;
    chk("data oe", 8'h00, {7'h00, s_oe});
    chk("vector", 8'h81, rd_data);
    wr(1'b0, 8'h0B);
    rd(1'b0, 8'h02, "service");
    wr(1'b0, 8'h20);
    slave_id = 3'h3;
    ack;
    ack;
    chk("data oe", 8'h01, {7'h00, s_oe});
    request_input = 8'h00;
    $display("test slave done");
  endtask : t_slave

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      complete_run();
    end
  end

  // Main sequence.
  initial begin
    step(20);
    rst = 1'b0;
    step(3);
    t_status();
    t_poll();
    t_req();
    t_master();
    t_slave();
    complete_run();
  end
endmodule : test_irq_status_poll_cascade
